// *** verilog/eeprom_pkg.sv ***
package eeprom_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 16;
  localparam int PAGE_W      = 7;
  localparam int DEPTH       = 65536;
  localparam int BYTE_W      = 8;
  localparam int PAGE_BYTES  = 128;

  // ----------------------------------------------------------------
  // Selection word
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_FIXED    = 4'h_A;
  localparam int         SEL_PIN_W    = 3;
  localparam int         SEL_FIX_LSB  = 4;
  localparam int         SEL_PIN_LSB  = 1;
  localparam int         SEL_RW_BIT   = 0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 200;
  localparam int WRITE_MS     = 5;
  localparam int WRITE_CYCLES = WRITE_MS * 1000 * CLK_MHZ;
  localparam int CNT_W        = 32;
  localparam logic [3:0] BIT_LAST = 4'h_7;
  localparam logic [3:0] BIT_ACK  = 4'h_8;

  // ----------------------------------------------------------------
  // Protocol states, gray coded along the usual path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SELECT = 3'b001,
    ST_ADDR_H = 3'b011,
    ST_ADDR_L = 3'b010,
    ST_WDATA  = 3'b110,
    ST_RDATA  = 3'b111,
    ST_IGNORE = 3'b101
  } proto_state_t;

endpackage : eeprom_pkg

// *** verilog/pin_sync.sv ***
`timescale 1ns/10ps
// Two-stage synchroniser with edge detection on the second stage output.
module pin_sync (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Pin side
  input  wire logic pin,
  // Synchronised level and edges
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_r, sync_r, prev_r;
  logic meta_nxt, sync_nxt, prev_nxt;

  // The first stage feeds only the second; bus idles high.
  always_comb begin
    meta_nxt = pin;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  // Register the chain.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign level = sync_r;
  assign rise  = sync_r & ~prev_r;
  assign fall  = ~sync_r & prev_r;

endmodule : pin_sync

// *** verilog/byte_buf2.sv ***
`timescale 1ns/10ps
// Two-entry buffer; a stalled drain never loses a word.
module byte_buf2 #(
  parameter int WIDTH = 24
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0] mem_r [2];
  logic [WIDTH-1:0] mem_nxt [2];
  logic             rd_r, wr_r, rd_nxt, wr_nxt;
  logic [1:0]       cnt_r, cnt_nxt;
  logic             push, pop;

  assign in_ready  = (cnt_r != 2'd2);
  assign out_valid = (cnt_r != 2'd0);
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer and occupancy update.
  always_comb begin
    mem_nxt = mem_r;
    if (push) begin
      mem_nxt[wr_r] = in_data;
    end
    wr_nxt  = wr_r ^ push;
    rd_nxt  = rd_r ^ pop;
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  // Register buffer state.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rd_r  <= 1'b0;
      wr_r  <= 1'b0;
      cnt_r <= 2'd0;
    end else begin
      rd_r  <= rd_nxt;
      wr_r  <= wr_nxt;
      cnt_r <= cnt_nxt;
    end
    mem_r <= mem_nxt;
  end

endmodule : byte_buf2

// *** verilog/eeprom_target.sv ***
`timescale 1ns/10ps
// Functional notes
// - Sample data on clock rise, launch outgoing data after clock fall.
// - Data pin is open drain: only ever pulled low.
// - Answer only when the three select bits match the strapped pins.
// - Floating select pins read low; tie them to a fixed level.
// - Write-protect high blocks every array write; low allows them.
// - Floating write-protect reads low, so writes stay enabled.
// - Array is 512 pages of 128 bytes, 16-bit word address.
// - Page writes up to 128 bytes; shorter writes allowed.
// - Internal write completes within 5 ms after the stop.
// - Data change while clock high is a start or stop.
// - Data falling while clock high is a start.
// - Data rising while clock high is a stop; read stop enters standby.
// - Eight-bit words, acknowledged low on the ninth clock.
// - Standby at power-up and after stop once internal work ends.
// - Start, nine clocks, start, stop leaves the interface ready.
// - Selection word: 1010, select bits, then read high/write low.
// - Page write advances low seven address bits, wrapping in page.
// - During internal write, ignore inputs and refuse the selection word.
// - Address counter holds last address plus one; reads wrap at top.
module eeprom_target #(
  parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Serial bus pins
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  // Straps
  input  wire logic [2:0] device_select_pins,
  input  wire logic       write_protect,
  // Status
  output logic            standby,
  output logic            write_busy
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic scl_s, scl_rise, scl_fall, sda_s, sda_rise, sda_fall;
  logic [2:0] sel_m_r, sel_s_r;
  logic       wp_m_r, wp_s_r;

  pin_sync u_scl (
    .clock (clock),
    .nrst  (nrst),
    .pin   (scl),
    .level (scl_s),
    .rise  (scl_rise),
    .fall  (scl_fall)
  );

  pin_sync u_sda (
    .clock (clock),
    .nrst  (nrst),
    .pin   (sda_in),
    .level (sda_s),
    .rise  (sda_rise),
    .fall  (sda_fall)
  );

  // Straps pass two flops; reset value low mirrors the pull-downs.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sel_m_r <= 3'h_0;
      sel_s_r <= 3'h_0;
      wp_m_r  <= 1'b0;
      wp_s_r  <= 1'b0;
    end else begin
      sel_m_r <= device_select_pins;
      sel_s_r <= sel_m_r;
      wp_m_r  <= write_protect;
      wp_s_r  <= wp_m_r;
    end
  end

  // Both pins share the same delay, so the level of one at the other's edge is safe.
  logic start_det, stop_det;
  assign start_det = sda_fall & scl_s;
  assign stop_det  = sda_rise & scl_s;

  // ----------------------------------------------------------------
  // Array and page buffer
  // ----------------------------------------------------------------
  logic [eeprom_pkg::BYTE_W-1:0] array_r [eeprom_pkg::DEPTH];
  logic [eeprom_pkg::BYTE_W-1:0] page_r  [eeprom_pkg::PAGE_BYTES];
  logic [eeprom_pkg::PAGE_BYTES-1:0] dirty_r, dirty_nxt;

  function automatic logic [eeprom_pkg::ADDR_W-1:0] page_inc(
    input logic [eeprom_pkg::ADDR_W-1:0] a);
    page_inc = {a[eeprom_pkg::ADDR_W-1:eeprom_pkg::PAGE_W],
                a[eeprom_pkg::PAGE_W-1:0] + 7'h_01};
  endfunction : page_inc

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  eeprom_pkg::proto_state_t st_r, st_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [7:0]  sh_r, sh_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [15:0] page_base_r, page_base_nxt;
  logic        lead_r, lead_nxt;
  logic        drv_r, drv_nxt;
  logic        wrote_r, wrote_nxt;
  logic        nack_r, nack_nxt;
  logic [7:0]  rd_byte;
  logic        commit;
  logic        wr_push;
  logic [7:0]  wr_push_data;
  logic [6:0]  wr_push_idx;
  logic [eeprom_pkg::CNT_W-1:0] wcnt_r, wcnt_nxt;
  logic        busy_r, busy_nxt;
  logic        in_rdy, buf_valid, buf_take;
  logic [14:0] buf_data;

  assign rd_byte = array_r[addr_r];

  // Word-level sequencing; bits move on clock edges found in the pin, starts and stops on data edges while the clock is high.
  always_comb begin
    st_nxt        = st_r;
    bit_nxt       = bit_r;
    sh_nxt        = sh_r;
    addr_nxt      = addr_r;
    page_base_nxt = page_base_r;
    lead_nxt      = lead_r;
    drv_nxt       = drv_r;
    wrote_nxt     = wrote_r;
    nack_nxt      = nack_r;
    commit        = 1'b0;
    wr_push       = 1'b0;
    wr_push_data  = sh_r;
    wr_push_idx   = addr_r[eeprom_pkg::PAGE_W-1:0];
    if (start_det) begin
      st_nxt  = busy_r ? eeprom_pkg::ST_IGNORE : eeprom_pkg::ST_SELECT;
      bit_nxt = 4'h_0;
      drv_nxt = 1'b0;
      lead_nxt = 1'b1; // The clock fall that closes a start carries no bit.
    end else if (stop_det) begin
      commit  = wrote_r & ~busy_r;
      wrote_nxt = 1'b0;
      st_nxt  = eeprom_pkg::ST_IDLE;
      drv_nxt = 1'b0;
    end else if (st_r != eeprom_pkg::ST_IDLE && st_r != eeprom_pkg::ST_IGNORE) begin
      if (scl_rise) begin
        if (bit_r == eeprom_pkg::BIT_ACK) begin
          nack_nxt = sda_s;
        end else begin
          sh_nxt = {sh_r[6:0], sda_s};
        end
      end else if (scl_fall) begin
        drv_nxt = 1'b0;
        if (lead_r) begin
          lead_nxt = 1'b0;
        end else if (bit_r == eeprom_pkg::BIT_LAST) begin
          bit_nxt = eeprom_pkg::BIT_ACK;
          unique case (st_r)
            eeprom_pkg::ST_SELECT: begin
              if (sh_r[7:eeprom_pkg::SEL_FIX_LSB] == eeprom_pkg::SEL_FIXED &&
                  sh_r[3:eeprom_pkg::SEL_PIN_LSB] == sel_s_r) begin
                drv_nxt = 1'b1;
              end else begin
                st_nxt  = eeprom_pkg::ST_IDLE;
              end
            end
            eeprom_pkg::ST_ADDR_H: begin
              addr_nxt[15:8] = sh_r;
              drv_nxt = 1'b1;
            end
            eeprom_pkg::ST_ADDR_L: begin
              addr_nxt[7:0] = sh_r;
              page_base_nxt = {addr_r[15:8], sh_r};
              drv_nxt = 1'b1;
            end
            eeprom_pkg::ST_WDATA: begin
              if (!wp_s_r) begin
                wr_push   = in_rdy;
                wrote_nxt = 1'b1;
              end
              addr_nxt = page_inc(addr_r);
              drv_nxt  = 1'b1;
            end
            eeprom_pkg::ST_RDATA: begin
              addr_nxt = addr_r + 16'h_0001;
              drv_nxt  = 1'b0;
            end
            default: st_nxt = eeprom_pkg::ST_IDLE;
          endcase
        end else if (bit_r == eeprom_pkg::BIT_ACK) begin
          bit_nxt = 4'h_0;
          unique case (st_r)
            eeprom_pkg::ST_SELECT: begin
              if (sh_r[eeprom_pkg::SEL_RW_BIT]) begin
                st_nxt  = eeprom_pkg::ST_RDATA;
                sh_nxt  = rd_byte;
                drv_nxt = ~rd_byte[7];
              end else begin
                st_nxt = eeprom_pkg::ST_ADDR_H;
              end
            end
            eeprom_pkg::ST_ADDR_H: st_nxt = eeprom_pkg::ST_ADDR_L;
            eeprom_pkg::ST_ADDR_L: st_nxt = eeprom_pkg::ST_WDATA;
            eeprom_pkg::ST_WDATA:  st_nxt = eeprom_pkg::ST_WDATA;
            eeprom_pkg::ST_RDATA: begin
              if (nack_r) begin
                st_nxt = eeprom_pkg::ST_IDLE;
              end else begin
                sh_nxt  = rd_byte;
                drv_nxt = ~rd_byte[7];
              end
            end
            default: st_nxt = eeprom_pkg::ST_IDLE;
          endcase
        end else begin
          bit_nxt = bit_r + 4'h_1;
          // The rising clock has already shifted, so the next bit now sits on top.
          if (st_r == eeprom_pkg::ST_RDATA) begin
            drv_nxt = ~sh_r[eeprom_pkg::BYTE_W-1];
          end
        end
      end
    end
  end

  // Register the protocol engine; power-up lands in standby.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_r        <= eeprom_pkg::ST_IDLE;
      bit_r       <= 4'h_0;
      sh_r        <= 8'h_00;
      addr_r      <= 16'h_0000;
      page_base_r <= 16'h_0000;
      lead_r      <= 1'b0;
      drv_r       <= 1'b0;
      wrote_r     <= 1'b0;
      nack_r      <= 1'b1;
    end else begin
      st_r        <= st_nxt;
      bit_r       <= bit_nxt;
      sh_r        <= sh_nxt;
      addr_r      <= addr_nxt;
      page_base_r <= page_base_nxt;
      lead_r      <= lead_nxt;
      drv_r       <= drv_nxt;
      wrote_r     <= wrote_nxt;
      nack_r      <= nack_nxt;
    end
  end

  // Open drain: output value is always low, enable low means drive.
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drv_r;

  // ----------------------------------------------------------------
  // Page staging through the two-entry buffer
  // ----------------------------------------------------------------
  assign buf_take = buf_valid;

  byte_buf2 #(
    .WIDTH (15)
  ) u_buf (
    .clock     (clock),
    .nrst      (nrst),
    .in_valid  (wr_push),
    .in_ready  (in_rdy),
    .in_data   ({wr_push_idx, wr_push_data}),
    .out_valid (buf_valid),
    .out_ready (buf_take),
    .out_data  (buf_data)
  );

  // Mark staged bytes; a commit retires them all.
  always_comb begin
    dirty_nxt = dirty_r;
    if (commit) begin
      dirty_nxt = '0;
    end
    if (buf_take) begin
      dirty_nxt[buf_data[14:8]] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Self-timed write
  // ----------------------------------------------------------------
  always_comb begin
    wcnt_nxt = wcnt_r;
    busy_nxt = busy_r;
    if (commit) begin
      busy_nxt = 1'b1;
      wcnt_nxt = WRITE_CYCLES[eeprom_pkg::CNT_W-1:0] - 32'h_0000_0001;
    end else if (busy_r) begin
      if (wcnt_r == '0) begin
        busy_nxt = 1'b0;
      end else begin
        wcnt_nxt = wcnt_r - 32'h_0000_0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      wcnt_r  <= '0;
      busy_r  <= 1'b0;
      dirty_r <= '0;
    end else begin
      wcnt_r  <= wcnt_nxt;
      busy_r  <= busy_nxt;
      dirty_r <= dirty_nxt;
    end
  end

  // Array and page storage; the staged (dirty) bytes of the page land at once when commit fires.
  always_ff @(posedge clock) begin
    if (buf_take) begin
      page_r[buf_data[14:8]] <= buf_data[7:0];
    end
    if (commit) begin
      for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
        if (dirty_r[i]) begin
          array_r[{page_base_r[15:7], i[6:0]}] <= page_r[i];
        end
      end
    end
  end

  assign write_busy = busy_r;
  assign standby    = (st_r == eeprom_pkg::ST_IDLE) & ~busy_r;

endmodule : eeprom_target

// *** bench/eeprom_target_sva.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checker for the serial memory target
// ------------------------------------------------------------
module eeprom_target_sva #(
  parameter int WRITE_CYCLES = 400
) (
  // Clock and reset
  input wire logic       clock,
  input wire logic       nrst,
  // Bus pins and straps
  input wire logic       scl,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  input wire logic [2:0] device_select_pins,
  input wire logic       write_protect,
  // Status
  input wire logic       standby,
  input wire logic       write_busy
);
  logic [31:0] busy_cnt_r;
  logic [31:0] busy_cnt_nxt;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // Length of the running self-timed write, so its upper bound can be held.
  always_comb begin
    busy_cnt_nxt = write_busy ? busy_cnt_r + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      busy_cnt_r <= 32'h0000_0000;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  od_low_a: assert property (sda_out == 1'b0)
    else $error("data pin value not low");
  rst_idle_a: assert property ($rose(nrst) |-> sda_oe_n && standby && !write_busy)
    else $error("not idle after reset");
  launch_low_a: assert property ($changed(sda_oe_n) |-> !scl)
    else $error("data launched while bus clock high");
  busy_std_a: assert property (write_busy |-> !standby)
    else $error("standby during internal write");
  busy_len_a: assert property (write_busy |-> busy_cnt_r <= 32'(WRITE_CYCLES))
    else $error("internal write too long");
  busy_quiet_a: assert property (write_busy |-> sda_oe_n)
    else $error("data pulled during internal write");
  wp_hold_a: assert property ($rose(write_busy) |-> !(write_protect && $past(write_protect, 8)))
    else $error("write started while protected");
  start_det_a: assert property (scl && $past(scl) && $fell(sda_in) && !write_busy
    |-> ##[2:8] !standby)
    else $error("start not seen");
  stop_det_a: assert property (scl && $past(scl) && $rose(sda_in)
    |-> ##[2:8] (standby || write_busy))
    else $error("stop not seen");

  busy_c: cover property ($rose(write_busy));
  ack_c: cover property ($fell(sda_oe_n));
  idle_c: cover property ($rose(standby));
endmodule : eeprom_target_sva

// *** bench/two_wire_ctl.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// Behavioural two-wire bus controller
// ------------------------------------------------------------
module two_wire_ctl (
  // Bus side
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  int hp = 24;

  // Idle bus: both lines released, the clock stands still between frames.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Data moves only in the clock low phase; the wire is taken at the rise.
  task automatic clk_bit(input logic b, output logic v);
    #(hp / 2) sda_low = !b;
    #(hp / 2) scl = 1'b1;
    v = sda;
    #(hp) scl = 1'b0;
  endtask : clk_bit

  // Start, also as a repeated start from the low phase.
  task automatic start;
    if (!scl) begin
      #(hp / 2) sda_low = 1'b0;
      #(hp / 2) scl = 1'b1;
    end
    #(hp) sda_low = 1'b1;
    #(hp) scl = 1'b0;
  endtask : start

  task automatic stop;
    #(hp / 2) sda_low = 1'b1;
    #(hp / 2) scl = 1'b1;
    #(hp) sda_low = 1'b0;
    #(hp);
  endtask : stop

  // Eight bits MSB first, then the acknowledge slot.
  task automatic xfer(input logic [7:0] tx, input logic b9, output logic [7:0] rx,
                      output logic v9);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(tx[i], v);
      rx[i] = v;
    end
    clk_bit(b9, v9);
  endtask : xfer
endmodule : two_wire_ctl

// *** bench/tb.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// Self-checking bench for the serial memory target
// ------------------------------------------------------------
module tb;
  localparam int WRC = 400;
  logic       clock;
  logic       nrst;
  logic       write_protect;
  logic [2:0] device_select_pins;
  logic       scl, sda_low, sda, sda_out, sda_oe_n, standby, write_busy;
  logic [7:0] mem [int];
  logic [7:0] rx;
  logic       v;
  logic [15:0] base;
  int         n_fail = 0;
  int         samples_checked = 0;
  int         cyc = 0;

  // Open-drain wire with a pull-up: low whenever any party pulls.
  assign sda = !(sda_low || (!sda_oe_n && !sda_out));

  two_wire_ctl ctl (.scl(scl), .sda_low(sda_low), .sda(sda));
  eeprom_target #(.WRITE_CYCLES(WRC)) DUT (
    .clock(clock), .nrst(nrst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .device_select_pins(device_select_pins),
    .write_protect(write_protect), .standby(standby), .write_busy(write_busy));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = !clock;
  end

  // A hang is cut short well above the expected run length.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      end_sim;
    end
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic [7:0] sel(input logic [2:0] p, input logic rd);
    return {eeprom_pkg::SEL_FIXED, p, rd};
  endfunction : sel

  // Bus events sit off the clock grid so no edge ever coincides.
  task automatic sync;
    @(posedge clock);
    #1.3;
  endtask : sync

  task automatic addr_phase(input logic [15:0] a);
    sync;
    ctl.start;
    ctl.xfer(sel(device_select_pins, 1'b0), 1'b1, rx, v);
    check("select ack", 8'h00, 8'(v));
    ctl.xfer(a[15:8], 1'b1, rx, v);
    check("addr high ack", 8'h00, 8'(v));
    ctl.xfer(a[7:0], 1'b1, rx, v);
    check("addr low ack", 8'h00, 8'(v));
  endtask : addr_phase

  task automatic wr_seq(input logic [15:0] a, input int n);
    logic [7:0] d;
    addr_phase(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      if (!write_protect) mem[{a[15:7], 7'(a[6:0] + 7'(i))}] = d;
      ctl.xfer(d, 1'b1, rx, v);
      check("data ack", 8'h00, 8'(v));
    end
    ctl.stop;
    for (int i = 0; i < 20 && write_busy !== 1'b1; i++) @(posedge clock);
    #1;
    check("busy start", 8'(!write_protect), 8'(write_busy));
    if (!write_protect) begin
      sync;
      ctl.start;
      ctl.xfer(sel(device_select_pins, 1'b0), 1'b1, rx, v);
      ctl.stop;
      check("poll nack", 8'h01, 8'(v));
      for (int i = 0; i < WRC + 50 && write_busy !== 1'b0; i++) @(posedge clock);
      #1;
      check("busy end", 8'h00, 8'(write_busy));
      check("standby", 8'h01, 8'(standby));
    end
  endtask : wr_seq

  task automatic rd_seq(input logic [15:0] a, input int n, input logic cur);
    if (!cur) addr_phase(a);
    else sync;
    ctl.start;
    ctl.xfer(sel(device_select_pins, 1'b1), 1'b1, rx, v);
    check("read select ack", 8'h00, 8'(v));
    for (int i = 0; i < n; i++) begin
      ctl.xfer(8'h_FF, 1'(i == n - 1), rx, v);
      check("read data", mem[16'(a + 16'(i))], rx);
    end
    ctl.stop;
    for (int i = 0; i < 10 && standby !== 1'b1; i++) @(posedge clock);
    #1;
    check("read standby", 8'h01, 8'(standby));
  endtask : rd_seq

  initial begin
    nrst = 1'b0;
    write_protect = 1'b0;
    device_select_pins = 3'h0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    check("idle flags", 8'h05, {5'h00, standby, write_busy, sda_oe_n});
    void'($urandom(4));
    @(posedge clock);
    device_select_pins <= 3'($urandom);
    base = {9'($urandom), 7'h00};
    wr_seq(base + 16'h007E, 130);
    rd_seq(base, 128, 1'b0);
    wr_seq(16'h_FFFE, 2);
    wr_seq(16'h0000, 1);
    ctl.hp = 60;
    rd_seq(16'h_FFFE, 3, 1'b0);
    ctl.hp = 24;
    @(posedge clock);
    write_protect <= 1'b1;
    wr_seq(16'h_FFFE, 2);
    @(posedge clock);
    write_protect <= 1'b0;
    rd_seq(16'h_FFFE, 2, 1'b0);
    rd_seq(16'h0000, 1, 1'b1);
    // Every select code; only the strapped one may answer.
    for (int p = 0; p < 8; p++) begin
      sync;
      ctl.start;
      ctl.xfer(sel(3'(p), 1'b1), 1'b1, rx, v);
      check("select match", 8'(3'(p) != device_select_pins), 8'(v));
      ctl.xfer(8'h_FF, 1'b1, rx, v);
      ctl.stop;
    end
    // Protocol reset: start, nine clocks, start, stop.
    sync;
    ctl.start;
    ctl.xfer(8'h_FF, 1'b1, rx, v);
    ctl.start;
    ctl.stop;
    rd_seq(16'h0000, 1, 1'b0);
    end_sim;
  end
endmodule : tb

bind eeprom_target eeprom_target_sva #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
  .clock(clock), .nrst(nrst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .device_select_pins(device_select_pins),
  .write_protect(write_protect), .standby(standby), .write_busy(write_busy));
